// File: hdl/srp_regs.vh
// constants for the short register peripheral port
// Behaviour
// - a transfer spans five phases T2,T3,T4,T5,T1, then restarts at T2.
// - at T4 the port drives four status bits onto accumulator bits 20-23.
// - power_good_flag false reports the tester unavailable.
// - status bit 21 mirrors the mode register block-transfer bit.
// - status bit 22 carries interrupt_pending.
// - status bit 23 carries tester_busy_flag from the execute delay counter.
// - respond only when instruction bits 0-7 hold our unit code.
// - at T4 device_selected steers bits 8-13,16,17 into address storage.
// - at T5 strobe the address is stored and decoded onto six select lines.
// - the register enabled at T5 transfers on the following T1.
// - a station control read drives 13 data bits toward the host at T1.
// - a write at T1 clocks the 24-bit host word into the addressed register.
// - bit 16 true marks a write; otherwise phases are identical.
// - the address storage clears at T2 of every cycle.
// - station control write latches bus bits 0,1 into head_connect_enable.
// - station control write pulses start set: stop clears, start rises.
// - panel start request stays latched until station control is read.
// - supply register takes 12 bits in parallel and applies them at once.
// - each short register loads by its own single transfer.
// - a memory_pointer write loads the long-register block start address.
// - a status register write sets bit 4, the trap enable, at T1.
// - last block trap bits with trap enable raise an interrupt, ending blocks.
// - mode register bit 9 hands control to the phase loop and delay counters.
`ifndef SRP_REGS_VH
`define SRP_REGS_VH
`define SRP_PH_T2 3'h0
`define SRP_PH_T3 3'h1
`define SRP_PH_T4 3'h2
`define SRP_PH_T5 3'h3
`define SRP_PH_T1 3'h4
`define SRP_UNIT_CODE 8'h50
`define SRP_ADDR_MODE 8'h01
`define SRP_ADDR_STATUS 8'h02
`define SRP_ADDR_PTR 8'h04
`define SRP_ADDR_STCTRL 8'h05
`define SRP_ADDR_SUPPLY 8'h11
`define SRP_BIT_WRITE 16
`define SRP_MODE_BLK 9
`define SRP_STAT_TRAPEN 4
`define SRP_STCTRL_START 2
`endif

// File: hdl/srp_port.v
// peripheral port carrying single transfers to the tester short registers
`timescale 1ns/1ps
`include "srp_regs.vh"
module srp_port (
    // clock and reset
    input wire clk_sys,
    input wire reset_n,
    // host cycle: phase pulse, phase number, select and strobe
    input wire phase_pulse,
    input wire [2:0] phase_num,
    input wire peripheral_select,
    input wire peripheral_data_strobe,
    // accumulator bus
    input wire [23:0] accumulator_bus_in,
    output reg [23:0] accumulator_bus_out,
    output reg accumulator_bus_oe,
    // tester side status and events
    input wire power_good_flag,
    input wire tester_busy_flag,
    input wire panel_start_request,
    input wire last_block_instr,
    input wire [1:0] trap_bits,
    // decoded selects and register outputs
    output reg [5:0] register_select_lines,
    output reg head_connect_enable,
    output reg start_set_pulse,
    output reg start_flag,
    output reg stop_flag,
    output reg interrupt_pending,
    output reg [23:0] memory_pointer,
    output reg [11:0] programmable_supply_reg,
    output reg [23:0] mode_reg,
    output reg [23:0] status_reg
);
    // pin inputs gathered so one loop can synchronise them all
    localparam NPIN = 6;
    wire [NPIN-1:0] pin_raw;
    wire [NPIN-1:0] pin_sync;
    assign pin_raw = {panel_start_request, tester_busy_flag,
        power_good_flag, peripheral_data_strobe, peripheral_select,
        phase_pulse};

    // two flip-flops per pin before any logic reads it; the host and the
    // tester panel keep their own timing, so every pin is asynchronous
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
            reg meta_q;
            reg sync_q;
            // first stage may go metastable, only the second is read
            always @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= pin_raw[gi];
                    sync_q <= meta_q;
                end
            end
            assign pin_sync[gi] = sync_q;
        end
    endgenerate

    // named views of the synchronised pins
    wire pulse_s = pin_sync[0];
    wire select_s = pin_sync[1];
    wire strobe_s = pin_sync[2];
    wire power_s = pin_sync[3];
    wire busy_s = pin_sync[4];
    wire panel_s = pin_sync[5];

    // phase number takes the same two stages as the phase pulse, so the
    // code seen at the pulse edge belongs to that pulse; the host holds
    // it steady for the whole phase, so no bit is caught mid-change
    reg [2:0] ph_meta_q;
    reg [2:0] ph_q;
    reg pulse_prev_q;
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ph_meta_q <= 3'h0;
            ph_q <= 3'h0;
            pulse_prev_q <= 1'b0;
        end else begin
            ph_meta_q <= phase_num;
            ph_q <= ph_meta_q;
            pulse_prev_q <= pulse_s;
        end
    end

    // one action per phase, on the rising edge of the pulse; the edge
    // detector resets low, the idle level of the pulse pin, so no false
    // edge follows reset
    wire phase_edge = pulse_s & ~pulse_prev_q;
    wire strobe = phase_edge & strobe_s;

    // phase decode: T2, T3, T4, T5, T1 in turn; T3 needs no action here
    wire edge_t2 = phase_edge & (ph_q == `SRP_PH_T2);
    wire edge_t4 = phase_edge & (ph_q == `SRP_PH_T4);
    wire strobe_t5 = strobe & (ph_q == `SRP_PH_T5);
    wire strobe_t1 = strobe & (ph_q == `SRP_PH_T1);

    // unit code match and peripheral select
    wire unit_match = (accumulator_bus_in[7:0] == `SRP_UNIT_CODE);
    wire device_selected = select_s & unit_match;

    // address board state
    reg [7:0] addr_in_q;
    reg [7:0] addr_q;
    reg wr_in_q;
    reg wr_q;
    reg sel_q;

    // transfer of the enabled register at T1, split by the write bit
    wire xfer_t1 = strobe_t1 & sel_q;
    wire wr_cycle = xfer_t1 & wr_q;
    wire rd_cycle = xfer_t1 & ~wr_q;
    wire [23:0] wdata = accumulator_bus_in;

    // register hits on the stored address
    wire hit_mode = (addr_q == `SRP_ADDR_MODE);
    wire hit_status = (addr_q == `SRP_ADDR_STATUS);
    wire hit_ptr = (addr_q == `SRP_ADDR_PTR);
    wire hit_stctrl = (addr_q == `SRP_ADDR_STCTRL);
    wire hit_supply = (addr_q == `SRP_ADDR_SUPPLY);

    // station control strobes for the write and the read
    wire station_ctrl_write_strobe = wr_cycle & hit_stctrl;
    wire stctrl_read = rd_cycle & hit_stctrl;

    // status bits; the host reads the tester as unavailable when power
    // is low, block mode is on or the tester is busy
    wire stat_power = power_s;
    wire stat_block = mode_reg[`SRP_MODE_BLK];
    wire stat_irq = interrupt_pending;
    wire stat_busy = busy_s;
    wire [3:0] stat4 = {stat_busy, stat_irq, stat_block, stat_power};

    // trap request from the last block instruction
    wire trap_decoded = last_block_instr & (|trap_bits);
    wire trap_fire = trap_decoded & status_reg[`SRP_STAT_TRAPEN];

    // address board: cleared at T2, loaded at T4, stored and decoded at
    // the T5 strobe; an empty address at T5 enables nothing, so a cycle
    // for another unit or without a strobe touches no register
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            addr_in_q <= 8'h00;
            addr_q <= 8'h00;
            wr_in_q <= 1'b0;
            wr_q <= 1'b0;
            sel_q <= 1'b0;
            register_select_lines <= 6'h00;
        end else if (edge_t2) begin
            // ready for the next instruction
            addr_in_q <= 8'h00;
            addr_q <= 8'h00;
            wr_in_q <= 1'b0;
            wr_q <= 1'b0;
            sel_q <= 1'b0;
            register_select_lines <= 6'h00;
        end else if (edge_t4 && device_selected) begin
            // bits 8-13 and 17 form the address, bit 16 the direction
            addr_in_q <= {accumulator_bus_in[17], 1'b0,
                accumulator_bus_in[13:8]};
            wr_in_q <= accumulator_bus_in[`SRP_BIT_WRITE];
        end else if (strobe_t5 && addr_in_q != 8'h00) begin
            // store and decode onto the select lines
            addr_q <= {2'b00, addr_in_q[5:0]};
            wr_q <= wr_in_q;
            sel_q <= 1'b1;
            register_select_lines <= addr_in_q[5:0];
        end
    end

    // read word of the enabled register; station control carries 13 bits
    // of which head enable, start and trap enable are implemented
    reg [23:0] rd_word;
    always @* begin
        rd_word = 24'h000000;
        case (addr_q)
        `SRP_ADDR_STCTRL: rd_word = {21'h0, status_reg[`SRP_STAT_TRAPEN],
            start_flag, head_connect_enable};
        `SRP_ADDR_PTR: rd_word = memory_pointer;
        `SRP_ADDR_MODE: rd_word = mode_reg;
        `SRP_ADDR_STATUS: rd_word = status_reg;
        default: rd_word = 24'h000000;
        endcase
    end

    // accumulator bus driver: status at T4 when selected, read data at
    // T1 only with the strobe; released at every other phase edge so the
    // host never sees a stale word driven
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            accumulator_bus_out <= 24'h000000;
            accumulator_bus_oe <= 1'b0;
        end else if (phase_edge) begin
            if (edge_t4 && device_selected) begin
                accumulator_bus_out <= {stat4, 20'h00000};
                accumulator_bus_oe <= 1'b1;
            end else if (rd_cycle) begin
                accumulator_bus_out <= rd_word;
                accumulator_bus_oe <= 1'b1;
            end else begin
                // nothing enabled, nothing driven
                accumulator_bus_oe <= 1'b0;
            end
        end
    end

    // short registers, each written by its own single transfer; a trap also clears mode bit 9
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            head_connect_enable <= 1'b0;
            memory_pointer <= 24'h000000;
            programmable_supply_reg <= 12'h000;
            mode_reg <= 24'h000000;
            status_reg <= 24'h000000;
        end else begin
            // either head enable bit connects the test head
            if (station_ctrl_write_strobe) begin
                head_connect_enable <= |wdata[1:0];
            end
            // start address of the long-register block
            if (wr_cycle && hit_ptr) begin
                memory_pointer <= wdata;
            end
            // the supply takes the new value as soon as it is loaded
            if (wr_cycle && hit_supply) begin
                programmable_supply_reg <= wdata[11:0];
            end
            // block mode bit hands the tester to the phase loop
            if (wr_cycle && hit_mode) begin
                mode_reg <= wdata;
            end
            // a trap ends block transfers and wins over a mode write
            if (trap_fire) begin
                mode_reg[`SRP_MODE_BLK] <= 1'b0;
            end
            // any status write arms the trap enable
            if (wr_cycle && hit_status) begin
                status_reg <= wdata;
                status_reg[`SRP_STAT_TRAPEN] <= 1'b1;
            end
        end
    end

    // interrupt request, raised by a trap and held
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            interrupt_pending <= 1'b0;
        end else if (trap_fire) begin
            interrupt_pending <= 1'b1;
        end
    end

    // start and stop flags: a station control write clears stop and
    // raises start; a panel request holds start until station control
    // is read, and a request in the cycle of the read clear wins
    reg st_rd_q;
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            start_set_pulse <= 1'b0;
            start_flag <= 1'b0;
            stop_flag <= 1'b1;
            st_rd_q <= 1'b0;
        end else begin
            // one clock wide, follows the write strobe
            start_set_pulse <= station_ctrl_write_strobe;
            st_rd_q <= stctrl_read;
            if (station_ctrl_write_strobe) begin
                stop_flag <= 1'b0;
            end
            if (station_ctrl_write_strobe || panel_s) begin
                start_flag <= 1'b1;
            end else if (st_rd_q) begin
                start_flag <= 1'b0;
            end
        end
    end
endmodule // srp_port

// File: dv/srp_port_monitor.sv
// checker of the short register port outputs
`timescale 1ns/1ps
module srp_port_monitor (
    // clock and reset
    input wire clk_sys,
    input wire reset_n,
    // host strobe and trap inputs
    input wire peripheral_data_strobe,
    input wire last_block_instr,
    input wire [1:0] trap_bits,
    // watched outputs
    input wire [5:0] register_select_lines,
    input wire head_connect_enable,
    input wire start_set_pulse,
    input wire start_flag,
    input wire stop_flag,
    input wire interrupt_pending,
    input wire [23:0] memory_pointer,
    input wire [11:0] programmable_supply_reg,
    input wire [23:0] status_reg
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // strobe seen through the two stage synchroniser
    sequence s_strb;
        $past(peripheral_data_strobe, 2);
    endsequence
    a_sel_strobe: assert property (($changed(register_select_lines) &&
        register_select_lines != 6'h00) |-> s_strb) else $error("select no strobe");
    a_ptr_load: assert property ($changed(memory_pointer) |-> s_strb)
        else $error("pointer loaded without strobe");
    a_supply_load: assert property ($changed(programmable_supply_reg)
        |-> s_strb) else $error("supply loaded without strobe");
    a_head_strobe: assert property ($rose(head_connect_enable) |-> s_strb)
        else $error("head enable without strobe");
    a_trapen_set: assert property ($rose(status_reg[4]) |-> s_strb)
        else $error("trap enable without strobe");
    a_pulse_single: assert property (start_set_pulse |=> !start_set_pulse)
        else $error("start set pulse too long");
    a_start_stop: assert property (start_set_pulse |-> ##[0:1]
        (start_flag && !stop_flag)) else $error("start not raised");
    a_trap_irq: assert property ((last_block_instr && (|trap_bits) &&
        status_reg[4]) |-> ##[0:2] interrupt_pending) else $error("no trap irq");
    a_idle_hold: assert property (!peripheral_data_strobe [*5] |->
        ($stable(memory_pointer) && $stable(programmable_supply_reg)))
        else $error("register changed while idle");
endmodule // srp_port_monitor
bind srp_port srp_port_monitor u_srp_port_monitor (.clk_sys(clk_sys),
    .reset_n(reset_n), .peripheral_data_strobe(peripheral_data_strobe),
    .last_block_instr(last_block_instr), .trap_bits(trap_bits),
    .register_select_lines(register_select_lines),
    .head_connect_enable(head_connect_enable),
    .start_set_pulse(start_set_pulse), .start_flag(start_flag),
    .stop_flag(stop_flag), .interrupt_pending(interrupt_pending),
    .memory_pointer(memory_pointer), .status_reg(status_reg),
    .programmable_supply_reg(programmable_supply_reg));

// File: dv/srp_host_model.sv
// host side model running one five phase cycle per request
`timescale 1ns/1ps
module srp_host_model (
    // clock and request from the bench
    input wire clk_sys,
    input wire go,
    input wire [23:0] instr,
    input wire [23:0] wdata,
    // port pins
    output reg phase_pulse = 1'b0,
    output reg [2:0] phase_num = 3'h0,
    output reg peripheral_select = 1'b0,
    output reg peripheral_data_strobe = 1'b0,
    output reg [23:0] accumulator_bus_in = 24'h000000,
    input wire [23:0] accumulator_bus_out,
    input wire accumulator_bus_oe,
    // results of the last cycle
    output reg done = 1'b0,
    output reg [3:0] stat = 4'h0,
    output reg [23:0] rdata = 24'h000000
);
    integer p;
    integer k;
    reg avail;
    // phases T2,T3,T4,T5,T1: a two cycle pulse then a quiet spell
    always begin
        @(posedge go);
        avail = 1'b0;
        for (p = 0; p < 5; p = p + 1) begin
            @(negedge clk_sys);
            phase_num <= p[2:0];
            peripheral_select <= (p == 2);
            peripheral_data_strobe <= (p > 2) && avail;
            accumulator_bus_in <= (p == 4 && instr[16]) ? wdata : instr;
            phase_pulse <= 1'b1;
            for (k = 0; k < 8; k = k + 1) begin
                @(negedge clk_sys);
                if (k == 1) phase_pulse <= 1'b0;
            end
            // a released bus shows the inverse of its last word
            if (p == 2) stat = accumulator_bus_oe ?
                accumulator_bus_out[23:20] : ~accumulator_bus_out[23:20];
            if (p == 2) avail = stat[0] && !stat[1] && !stat[3];
            if (p == 4) rdata = accumulator_bus_oe ?
                accumulator_bus_out : ~accumulator_bus_out;
        end
        @(negedge clk_sys);
        peripheral_data_strobe <= 1'b0;
        done <= ~done;
    end
endmodule // srp_host_model

// File: dv/srp_port_tb.sv
// testbench for the short register peripheral port
`timescale 1ns/1ps
`include "srp_regs.vh"
module srp_port_tb;
    reg clk_sys = 1'b0;
    reg reset_n = 1'b0;
    reg go = 1'b0;
    reg [23:0] instr = 24'h000000;
    reg [23:0] wdata = 24'h000000;
    reg power_good_flag = 1'b0;
    reg tester_busy_flag = 1'b0;
    reg panel_start_request = 1'b0;
    reg last_block_instr = 1'b0;
    reg [1:0] trap_bits = 2'h0;
    wire phase_pulse, peripheral_select, peripheral_data_strobe, done;
    wire head_connect_enable, start_flag, stop_flag, interrupt_pending;
    wire [2:0] phase_num;
    wire [3:0] stat;
    wire bus_oe;
    wire [11:0] programmable_supply_reg;
    wire [23:0] accumulator_bus_in, accumulator_bus_out, rdata;
    wire [23:0] memory_pointer, mode_reg, status_reg;
    integer n_errors = 0;
    integer total_checks = 0;
    integer cyc = 0;
    srp_port u_srp_port (.clk_sys(clk_sys), .reset_n(reset_n),
        .phase_pulse(phase_pulse), .phase_num(phase_num),
        .peripheral_select(peripheral_select),
        .peripheral_data_strobe(peripheral_data_strobe),
        .accumulator_bus_in(accumulator_bus_in),
        .accumulator_bus_out(accumulator_bus_out), .accumulator_bus_oe(bus_oe),
        .power_good_flag(power_good_flag), .tester_busy_flag(tester_busy_flag),
        .panel_start_request(panel_start_request),
        .last_block_instr(last_block_instr), .trap_bits(trap_bits),
        .register_select_lines(), .head_connect_enable(head_connect_enable),
        .start_set_pulse(), .start_flag(start_flag), .stop_flag(stop_flag),
        .interrupt_pending(interrupt_pending), .mode_reg(mode_reg),
        .memory_pointer(memory_pointer), .status_reg(status_reg),
        .programmable_supply_reg(programmable_supply_reg));
    srp_host_model u_srp_host_model (.clk_sys(clk_sys), .go(go),
        .instr(instr), .wdata(wdata), .phase_pulse(phase_pulse),
        .phase_num(phase_num), .peripheral_select(peripheral_select),
        .peripheral_data_strobe(peripheral_data_strobe),
        .accumulator_bus_in(accumulator_bus_in),
        .accumulator_bus_out(accumulator_bus_out),
        .accumulator_bus_oe(bus_oe), .done(done),
        .stat(stat), .rdata(rdata));
    initial forever #10 clk_sys = ~clk_sys;
    // compare one value and count it
    task chk(input string what, input [23:0] seen, input [23:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one host cycle: unit code, address, write flag and data word
    task xfer(input [7:0] unit, input [7:0] addr, input wr, input [23:0] d);
        reg d0;
        d0 = done;
        instr = {6'h00, addr[7], wr, 2'b00, addr[5:0], unit};
        wdata = d;
        @(negedge clk_sys);
        go = 1'b1;
        @(negedge clk_sys);
        go = 1'b0;
        while (done === d0) @(negedge clk_sys);
    endtask
    task t_avail;
        power_good_flag = 1'b0;
        xfer(`SRP_UNIT_CODE, `SRP_ADDR_SUPPLY, 1'b1, 24'h000456);
        chk("status", stat, 4'h0);
        chk("supply", programmable_supply_reg, 12'h000);
        power_good_flag = 1'b1;
        $display("test avail done");
    endtask
    task t_regs;
        xfer(`SRP_UNIT_CODE, `SRP_ADDR_SUPPLY, 1'b1, 24'h000abc);
        chk("supply", programmable_supply_reg, 12'habc);
        xfer(`SRP_UNIT_CODE, `SRP_ADDR_PTR, 1'b1, 24'h123456);
        chk("pointer", memory_pointer, 24'h123456);
        xfer(8'h51, `SRP_ADDR_PTR, 1'b1, 24'h654321);
        chk("foreign", memory_pointer, 24'h123456);
        $display("test regs done");
    endtask
    task t_stctrl;
        xfer(`SRP_UNIT_CODE, `SRP_ADDR_STCTRL, 1'b1, 24'h000001);
        chk("head", head_connect_enable, 1'b1);
        chk("start", {start_flag, stop_flag}, 2'b10);
        chk("oe write", bus_oe, 1'b0);
        xfer(`SRP_UNIT_CODE, `SRP_ADDR_STCTRL, 1'b0, 24'h000000);
        chk("read lo", rdata[2:0], 3'h3);
        chk("read hi", rdata[23:13], 11'h000);
        chk("status", stat, 4'h1);
        chk("oe read", bus_oe, 1'b1);
        chk("start clr", start_flag, 1'b0);
        panel_start_request = 1'b1;
        repeat (4) @(negedge clk_sys);
        panel_start_request = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk("panel start", start_flag, 1'b1);
        $display("test stctrl done");
    endtask
    task t_flags;
        tester_busy_flag = 1'b1;
        xfer(`SRP_UNIT_CODE, `SRP_ADDR_STCTRL, 1'b0, 24'h000000);
        chk("busy", stat, 4'h9);
        tester_busy_flag = 1'b0;
        xfer(`SRP_UNIT_CODE, `SRP_ADDR_STATUS, 1'b1, 24'h000010);
        chk("trap en", status_reg[4], 1'b1);
        xfer(`SRP_UNIT_CODE, `SRP_ADDR_MODE, 1'b1, 24'h000200);
        chk("mode", mode_reg[9], 1'b1);
        xfer(`SRP_UNIT_CODE, `SRP_ADDR_STCTRL, 1'b0, 24'h000000);
        chk("blk bit", stat, 4'h3);
        last_block_instr = 1'b1;
        trap_bits = 2'h1;
        repeat (3) @(negedge clk_sys);
        last_block_instr = 1'b0;
        chk("irq", interrupt_pending, 1'b1);
        xfer(`SRP_UNIT_CODE, `SRP_ADDR_STCTRL, 1'b0, 24'h000000);
        chk("irq bit", stat[2], 1'b1);
        $display("test flags done");
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // cycle ceiling against a hung transfer
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors = n_errors + 1;
            stop_test;
        end
    end
    initial begin
        repeat (8) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        t_avail;
        t_regs;
        t_stctrl;
        t_flags;
        stop_test;
    end
endmodule // srp_port_tb
